/* File: defi_pkg.sv */
// Package with register map, field positions and types for the event flags
package defi_pkg;
   localparam logic [6:0] CHECK_INTERRUPT_ENABLE_ADDR = 7'h05;
   localparam logic [6:0] EVENT_FLAGS_ADDR = 7'h06;
   localparam logic [6:0] CHECK_RESULT_ADDR = 7'h07;
   localparam logic [7:0] CHECK_INTERRUPT_ENABLE_RESET = 8'h00;
   localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
   localparam logic [7:0] CHECK_RESULT_RESET = 8'h00;
   localparam logic [7:0] CHECK_ENABLE_MASK = 8'h1c;
   localparam logic [7:0] EVENT_FLAGS_MASK = 8'hf3;
   localparam int EN_AVG_PASS = 4;
   localparam int EN_AVG_FAIL = 3;
   localparam int EN_SMP_FAIL = 2;
   localparam int EV_PLL_LOST = 7;
   localparam int EV_PLL_LOCKED = 6;
   localparam int EV_SYNC_LOST = 5;
   localparam int EV_SYNC_LOCKED = 4;
   localparam int EV_FIFO_WARN1 = 1;
   localparam int EV_FIFO_WARN2 = 0;
   localparam int SYNC_QUIET_CYCLES = 4;
   localparam logic [1:0] FIFO_DIST_WARN1 = 2'h1;
   localparam logic [1:0] FIFO_DIST_WARN2 = 2'h2;

   // Register write request from the serial port
   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] data;
   } defi_wr_t;

   // Status inputs from the PLL, sync and FIFO machinery
   typedef struct packed {
      logic pll_lock;
      logic sync_aligned;
      logic sync_phase_req;
      logic sync_avg_done;
      logic [1:0] fifo_dist;
      logic avg_pass;
      logic avg_fail;
      logic smp_fail;
   } defi_status_t;
endpackage

/* File: defi_event_flags.sv */
// Interrupt enable and event flag registers of the converter control set
// Functional notes
// - Enable bit 4 gates averaged-check pass interrupt
// - Enable bit 3 gates averaged-check fail interrupt
// - Enable bit 2 gates sample-check fail interrupt
// - Flag 7 latches PLL lock lost
// - Flag 6 sets when PLL locks
// - Flag 5 latches sync alignment lost
// - Flag 4 sets after quiet averaging cycles
// - Flag 1 sets at FIFO distance one
// - Flag 0 sets at FIFO distance two
// - Writing one clears a flag, zero keeps
`timescale 1ns/1ps
module defi_event_flags #(
   parameter int QUIET_CYCLES = defi_pkg::SYNC_QUIET_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port, same clock domain
   input wire defi_pkg::defi_wr_t reg_wr,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   // Event sources, already in this clock domain
   input wire defi_pkg::defi_status_t status,
   // Interrupt
   output logic irq
);
   // Counter width that holds any quiet length without wrapping
   localparam int QUIET_W =
      (QUIET_CYCLES < 1) ? 1 : $clog2(QUIET_CYCLES + 1);

   // Register state
   logic [7:0] enable_reg;
   logic [7:0] flags_reg;
   logic [7:0] check_reg;
   logic [QUIET_W-1:0] quiet_cnt;
   // Decoded write strobes
   logic enable_wr;
   logic flags_wr;
   logic check_wr;
   // Event and clear terms
   logic pll_fell;
   logic sync_fell;
   logic quiet_done;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic [7:0] check_set;
   logic [7:0] check_clr;
   logic irq_next;

   // One strobe per register; writes to other addresses are ignored here
   assign enable_wr = reg_wr.wr &&
      (reg_wr.addr == defi_pkg::CHECK_INTERRUPT_ENABLE_ADDR);
   assign flags_wr = reg_wr.wr &&
      (reg_wr.addr == defi_pkg::EVENT_FLAGS_ADDR);
   assign check_wr = reg_wr.wr &&
      (reg_wr.addr == defi_pkg::CHECK_RESULT_ADDR);

   // Only the three check enables exist; reserved bits are not stored, so a
   // careless write there can never raise a stray interrupt
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_reg <= defi_pkg::CHECK_INTERRUPT_ENABLE_RESET;
      end else if (enable_wr) begin
         enable_reg <= reg_wr.data & defi_pkg::CHECK_ENABLE_MASK;
      end
   end

   // Count full averaging cycles with no phase request; the count holds at
   // its target so a long quiet spell cannot wrap it back to zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_cnt <= '0;
      end else if (status.sync_phase_req) begin
         quiet_cnt <= '0;
      end else if (status.sync_avg_done && !quiet_done) begin
         quiet_cnt <= quiet_cnt + QUIET_W'(1);
      end
   end
   assign quiet_done = (quiet_cnt >= QUIET_W'(QUIET_CYCLES));

   // Lock lost: a previously locked PLL drops its lock level
   defi_fall_detect #(.IDLE_LEVEL(1'b0)) i_pll_fall (
      .clk(clk),
      .reset_n(reset_n),
      .level(status.pll_lock),
      .fell(pll_fell)
   );

   // Alignment lost: a previously aligned sync drops its level
   defi_fall_detect #(.IDLE_LEVEL(1'b0)) i_sync_fall (
      .clk(clk),
      .reset_n(reset_n),
      .level(status.sync_aligned),
      .fell(sync_fell)
   );

   // Event set terms; the locked and warning terms follow their levels, so
   // those flags come back after a clear while the condition lasts
   always_comb begin
      set_vec = 8'h00;
      set_vec[defi_pkg::EV_PLL_LOST] = pll_fell;
      set_vec[defi_pkg::EV_PLL_LOCKED] = status.pll_lock;
      set_vec[defi_pkg::EV_SYNC_LOST] = sync_fell;
      set_vec[defi_pkg::EV_SYNC_LOCKED] = quiet_done;
      set_vec[defi_pkg::EV_FIFO_WARN1] =
         (status.fifo_dist == defi_pkg::FIFO_DIST_WARN1);
      set_vec[defi_pkg::EV_FIFO_WARN2] =
         (status.fifo_dist == defi_pkg::FIFO_DIST_WARN2);
   end

   // Write-one-to-clear for the event flags; zeros leave a flag alone
   always_comb begin
      clr_vec = 8'h00;
      if (flags_wr) begin
         clr_vec = reg_wr.data & defi_pkg::EVENT_FLAGS_MASK;
      end
   end

   // Sticky event flags; a set in the clearing cycle wins, so an event that
   // lands on the clear is never lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_reg <= defi_pkg::EVENT_FLAGS_RESET;
      end else begin
         flags_reg <= (flags_reg & ~clr_vec) | set_vec;
      end
   end

   // Comparison events land on the bit positions of their enables
   always_comb begin
      check_set = 8'h00;
      check_set[defi_pkg::EN_AVG_PASS] = status.avg_pass;
      check_set[defi_pkg::EN_AVG_FAIL] = status.avg_fail;
      check_set[defi_pkg::EN_SMP_FAIL] = status.smp_fail;
   end

   // Write-one-to-clear for the latched comparison results
   always_comb begin
      check_clr = 8'h00;
      if (check_wr) begin
         check_clr = reg_wr.data & defi_pkg::CHECK_ENABLE_MASK;
      end
   end

   // Latched comparison results that the check enables gate; a result is
   // latched even while masked, so enabling later still reports it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         check_reg <= defi_pkg::CHECK_RESULT_RESET;
      end else begin
         check_reg <= (check_reg & ~check_clr) | check_set;
      end
   end

   // Readback of the two registers; other addresses read zero
   // The latched results are not readable on this port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else if (rd_addr == defi_pkg::CHECK_INTERRUPT_ENABLE_ADDR) begin
         rd_data <= enable_reg;
      end else if (rd_addr == defi_pkg::EVENT_FLAGS_ADDR) begin
         rd_data <= flags_reg;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // Interrupt request from enabled check results only; the event flags
   // have their enables in a neighbouring register outside this block
   always_comb begin
      irq_next = 1'b0;
      if (check_reg[defi_pkg::EN_AVG_PASS] &&
          enable_reg[defi_pkg::EN_AVG_PASS]) begin
         irq_next = 1'b1;
      end
      if (check_reg[defi_pkg::EN_AVG_FAIL] &&
          enable_reg[defi_pkg::EN_AVG_FAIL]) begin
         irq_next = 1'b1;
      end
      if (check_reg[defi_pkg::EN_SMP_FAIL] &&
          enable_reg[defi_pkg::EN_SMP_FAIL]) begin
         irq_next = 1'b1;
      end
   end

   // Registered so the interrupt pin never glitches
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end
endmodule

// Falling-edge detector for a status level; the stored level resets to
// the idle level so a released reset cannot fake an edge
module defi_fall_detect #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched level and its falling edge
   input wire logic level,
   output logic fell
);
   logic level_reg;

   // Level seen at the previous edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_reg <= IDLE_LEVEL;
      end else begin
         level_reg <= level;
      end
   end

   // High for the one cycle in which the level drops
   assign fell = level_reg && !level;
endmodule

/* File: defi_event_flags_asserts.sv */
// Checker for the enable register, event flags and interrupt output
`timescale 1ns/1ps
module defi_event_flags_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched ports
   input wire defi_pkg::defi_wr_t reg_wr,
   input wire logic [6:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire defi_pkg::defi_status_t status,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Readback is registered, so each check waits one extra edge
   chk_enable_store: assert property (
      reg_wr.wr && reg_wr.addr == 7'h05 ##1 rd_addr == 7'h05
      |=> rd_data == ($past(reg_wr.data, 2) & 8'h1c))
      else $error("enable readback wrong");
   chk_pll_lost: assert property (
      $fell(status.pll_lock) ##1 rd_addr == 7'h06 |=> rd_data[7])
      else $error("lock lost flag missing");
   chk_pll_locked: assert property (
      status.pll_lock ##1 rd_addr == 7'h06 |=> rd_data[6])
      else $error("locked flag missing");
   chk_sync_lost: assert property (
      $fell(status.sync_aligned) ##1 rd_addr == 7'h06 |=> rd_data[5])
      else $error("sync lost missing");
   chk_fifo_one: assert property (
      status.fifo_dist == 2'h1 ##1 rd_addr == 7'h06 |=> rd_data[1])
      else $error("warning one missing");
   chk_fifo_two: assert property (
      status.fifo_dist == 2'h2 ##1 rd_addr == 7'h06 |=> rd_data[0])
      else $error("warning two missing");
   chk_flag_clear: assert property (
      reg_wr.wr && reg_wr.addr == 7'h06 && reg_wr.data[1] &&
      status.fifo_dist != 2'h1 ##1 rd_addr == 7'h06 |=> !rd_data[1])
      else $error("flag not cleared");
   chk_irq_off: assert property (
      reg_wr.wr && reg_wr.addr == 7'h05 && reg_wr.data == 8'h00
      |-> ##2 !irq)
      else $error("irq stays high");
endmodule
bind defi_event_flags defi_event_flags_chk i_chk (.clk(clk),
   .reset_n(reset_n), .reg_wr(reg_wr), .rd_addr(rd_addr),
   .rd_data(rd_data), .status(status), .irq(irq));

/* File: defi_event_flags_test.sv */
// Register level testbench for the event flag block
`timescale 1ns/1ps
module defi_event_flags_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   defi_pkg::defi_wr_t reg_wr = '0;
   logic [6:0] rd_addr = 7'h00;
   defi_pkg::defi_status_t status = '0;
   logic [7:0] rd_data;
   logic irq;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   defi_event_flags #(.QUIET_CYCLES(4)) i_defi_event_flags (.clk(clk),
      .reset_n(reset_n), .reg_wr(reg_wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .status(status), .irq(irq));
   // Inputs always move 1 ns after the edge
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp(logic [7:0] got, logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(logic got, logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t irq %b want %b", $time, got, exp);
      end
   endtask
   // Writes with reserved enable bits zero are kept by callers
   task automatic wr(logic [6:0] a, logic [7:0] d);
      reg_wr = '{1'b1, a, d};
      tick();
      reg_wr.wr = 1'b0;
   endtask
   task automatic rd(logic [6:0] a, logic [7:0] exp);
      rd_addr = a;
      tick();
      cmp(rd_data, exp);
   endtask
   task automatic avg(int n);
      repeat (n) begin
         status.sync_avg_done = 1'b1;
         tick();
         status.sync_avg_done = 1'b0;
         tick();
      end
   endtask
   task automatic conclude;
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Guard against a hang; the tests need about 100 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         $display("FAIL %0t timeout", $time);
         conclude();
      end
   end
   initial begin
      tick(20);
      reset_n = 1'b1;
      rd(7'h05, 8'h00);
      rd(7'h06, 8'h00);
      wr(7'h05, 8'h1c);
      rd(7'h05, 8'h1c);
      status.pll_lock = 1'b1;
      tick();
      rd(7'h06, 8'h40);
      status.pll_lock = 1'b0;
      tick();
      wr(7'h06, 8'h40);
      rd(7'h06, 8'h80);
      wr(7'h06, 8'h80);
      rd(7'h06, 8'h00);
      status.sync_aligned = 1'b1;
      avg(3);
      status.sync_phase_req = 1'b1;
      avg(3);
      status.sync_phase_req = 1'b0;
      avg(3);
      rd(7'h06, 8'h00);
      avg(1);
      rd(7'h06, 8'h10);
      status.sync_aligned = 1'b0;
      status.sync_phase_req = 1'b1;
      tick();
      status.sync_phase_req = 1'b0;
      rd(7'h06, 8'h30);
      wr(7'h06, 8'h30);
      rd(7'h06, 8'h00);
      for (int v = 1; v < 4; v++) begin
         status.fifo_dist = v[1:0];
         tick();
      end
      status.fifo_dist = 2'h0;
      rd(7'h06, 8'h03);
      wr(7'h06, 8'h01);
      rd(7'h06, 8'h02);
      wr(7'h06, 8'h02);
      rd(7'h06, 8'h00);
      // Each check source: masked, enabled, then cleared at 0x07
      for (int i = 2; i < 5; i++) begin
         wr(7'h05, 8'h00);
         status[i-2] = 1'b1;
         tick();
         status[i-2] = 1'b0;
         tick(2);
         cmp_bit(irq, 1'b0);
         wr(7'h05, 8'h01 << i);
         tick(2);
         cmp_bit(irq, 1'b1);
         rd(7'h07, 8'h00);
         wr(7'h07, 8'h01 << i);
         tick(2);
         cmp_bit(irq, 1'b0);
      end
      conclude();
   end
endmodule
